// File: rtl/smcs_pkg.sv
package smcs_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_TXW = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    localparam logic [7:0] OFF_CFG0 = 8'h30;
    // control register bits
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DIS_BIT = 1;
    localparam int CTRL_LAST_BIT = 24;
    // mode register fields
    localparam int MODE_SRC_BIT = 1;
    localparam int MODE_DEC_BIT = 2;
    localparam int MODE_MFD_BIT = 4;
    localparam int MODE_RSRC_BIT = 3;
    localparam int MODE_SEL_LSB = 16;
    // transmit word fields
    localparam int TXW_SEL_LSB = 16;
    localparam int TXW_LAST_BIT = 24;
    // slave config fields
    localparam int CFG_HOLD_BIT = 3;
    localparam int CFG_REL_BIT = 2;
    localparam int CFG_BITS_LSB = 4;
    localparam int CFG_DIV_LSB = 8;
    localparam int CFG_DBS_LSB = 24;
    // status bits
    localparam int ST_DONE_BIT = 0;
    localparam int ST_EMPTY_BIT = 1;
    localparam int ST_BAD_BIT = 2;
    localparam int ST_ENA_BIT = 16;
    localparam logic [3:0] SEL_IDLE = 4'hF;
    localparam logic [3:0] BITS_MAX = 4'h8;
    localparam logic [4:0] BITS_BASE = 5'h08;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    // gap after the last bit of each character, select still driven, ns
    localparam int REL_GAP_NS = 40;
    localparam int CLK_NS = 40;
    localparam int REL_GAP_CYC = (REL_GAP_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {SMCS_IDLE, SMCS_LEAD, SMCS_SHIFT, SMCS_GAP} smcs_state_t;
endpackage : smcs_pkg

// File: rtl/smcs_master.sv
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
module smcs_master (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial link
    output logic serial_clock_out,
    output logic mosi,
    input wire logic miso,
    output logic [3:0] sel_n,
    // dma request and interrupt
    output logic tx_dma_req,
    output logic irq
);
    // bus address-phase capture
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_rdata;
    // registers
    logic enabled, next_enabled;
    logic [31:0] mode_register, next_mode_register;
    logic [31:0] cfg [4];
    logic [31:0] next_cfg [4];
    logic [31:0] txw, next_txw;
    logic txw_full, next_txw_full;
    logic [2:0] stat, next_stat;
    logic [2:0] mask, next_mask;
    logic last_req, next_last_req;
    // shifter
    smcs_pkg::smcs_state_t st, next_st;
    logic [15:0] shreg, next_shreg;
    logic [4:0] bitcnt, next_bitcnt;
    logic [7:0] divcnt, next_divcnt;
    logic [7:0] div_cur, next_div_cur;
    logic sck, next_sck;
    logic [3:0] sel, next_sel;
    logic [3:0] held, next_held;
    logic hold_cur, next_hold_cur;
    logic rel_cur, next_rel_cur;
    logic last_cur, next_last_cur;
    logic [1:0] gapcnt, next_gapcnt;
    logic mosi_r, next_mosi_r;
    logic miso_s1, miso_s2;
    logic [15:0] rx_word, next_rx_word;

    // combinational selection helpers
    logic [3:0] req_sel;
    logic [1:0] cfg_idx;
    logic [3:0] line_code;
    always_comb begin
        req_sel = mode_register[smcs_pkg::MODE_SRC_BIT] ? txw[smcs_pkg::TXW_SEL_LSB +: 4]
                                                        : mode_register[smcs_pkg::MODE_SEL_LSB +: 4];
        if (mode_register[smcs_pkg::MODE_DEC_BIT]) begin
            cfg_idx = req_sel[3:2];
            line_code = req_sel;
        end else begin
            if (!req_sel[0]) begin
                cfg_idx = 2'd0;
                line_code = 4'hE;
            end else if (!req_sel[1]) begin
                cfg_idx = 2'd1;
                line_code = 4'hD;
            end else if (!req_sel[2]) begin
                cfg_idx = 2'd2;
                line_code = 4'hB;
            end else begin
                cfg_idx = 2'd3;
                line_code = req_sel[3] ? smcs_pkg::SEL_IDLE : 4'h7;
            end
        end
    end

    // bus, register and serial engine next state
    logic ap_valid;
    logic [3:0] bits_code;
    logic done_ev, bad_ev;
    always_comb begin
        ap_valid = hsel && hready && htrans[1];
        next_wr_pend = ap_valid && hwrite;
        next_wr_addr = ap_valid ? haddr : wr_addr;
        next_rdata = smcs_pkg::RESET_ZERO;
        next_enabled = enabled;
        next_mode_register = mode_register;
        next_cfg = cfg;
        next_txw = txw;
        next_txw_full = txw_full;
        next_stat = stat;
        next_mask = mask;
        next_last_req = last_req;
        next_st = st;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_divcnt = divcnt;
        next_div_cur = div_cur;
        next_sck = sck;
        next_sel = sel;
        next_held = held;
        next_hold_cur = hold_cur;
        next_rel_cur = rel_cur;
        next_last_cur = last_cur;
        next_gapcnt = gapcnt;
        next_mosi_r = mosi_r;
        next_rx_word = rx_word;
        done_ev = 1'b0;
        bad_ev = 1'b0;
        bits_code = cfg[cfg_idx][smcs_pkg::CFG_BITS_LSB +: 4];
        // register reads
        if (ap_valid && !hwrite) begin
            case (haddr)
                smcs_pkg::OFF_MODE: next_rdata = mode_register;
                smcs_pkg::OFF_STAT: next_rdata = {15'h0000, enabled, 13'h0000, stat};
                smcs_pkg::OFF_MASK: next_rdata = {29'h0000_0000, mask};
                smcs_pkg::OFF_TXW: next_rdata = {16'h0000, rx_word};
                smcs_pkg::OFF_CFG0: next_rdata = cfg[0];
                smcs_pkg::OFF_CFG0 + 8'h04: next_rdata = cfg[1];
                smcs_pkg::OFF_CFG0 + 8'h08: next_rdata = cfg[2];
                smcs_pkg::OFF_CFG0 + 8'h0C: next_rdata = cfg[3];
                default: next_rdata = smcs_pkg::RESET_ZERO;
            endcase
        end
        // register writes in the data phase
        if (wr_pend) begin
            case (wr_addr)
                smcs_pkg::OFF_CTRL: begin
                    if (hwdata[smcs_pkg::CTRL_EN_BIT]) next_enabled = 1'b1;
                    if (hwdata[smcs_pkg::CTRL_DIS_BIT]) next_enabled = 1'b0;
                    if (hwdata[smcs_pkg::CTRL_LAST_BIT]) next_last_req = 1'b1;
                end
                smcs_pkg::OFF_MODE: next_mode_register = hwdata;
                smcs_pkg::OFF_TXW: begin
                    next_txw = hwdata;
                    next_txw_full = 1'b1;
                end
                smcs_pkg::OFF_STAT: next_stat = stat & ~hwdata[2:0];
                smcs_pkg::OFF_MASK: next_mask = hwdata[2:0];
                smcs_pkg::OFF_CFG0: next_cfg[0] = hwdata;
                smcs_pkg::OFF_CFG0 + 8'h04: next_cfg[1] = hwdata;
                smcs_pkg::OFF_CFG0 + 8'h08: next_cfg[2] = hwdata;
                smcs_pkg::OFF_CFG0 + 8'h0C: next_cfg[3] = hwdata;
                default: ;
            endcase
        end
        // serial engine
        case (st)
            smcs_pkg::SMCS_IDLE: begin
                if (enabled && txw_full && held != smcs_pkg::SEL_IDLE && held != line_code) begin
                    // a held line is let go for one cycle before another select is driven
                    next_sel = smcs_pkg::SEL_IDLE;
                    next_held = smcs_pkg::SEL_IDLE;
                end else if (enabled && txw_full) begin
                    next_txw_full = 1'b0;
                    if (bits_code > smcs_pkg::BITS_MAX
                        || cfg[cfg_idx][smcs_pkg::CFG_DIV_LSB +: 8] == 8'h00) begin
                        bad_ev = 1'b1;
                    end else begin
                        next_shreg = txw[15:0] << (smcs_pkg::BITS_MAX - bits_code); // left aligned
                        next_bitcnt = smcs_pkg::BITS_BASE + {1'b0, bits_code};
                        next_div_cur = cfg[cfg_idx][smcs_pkg::CFG_DIV_LSB +: 8];
                        next_hold_cur = cfg[cfg_idx][smcs_pkg::CFG_HOLD_BIT];
                        next_rel_cur = cfg[cfg_idx][smcs_pkg::CFG_REL_BIT]
                                       && !cfg[cfg_idx][smcs_pkg::CFG_HOLD_BIT];
                        next_last_cur = mode_register[smcs_pkg::MODE_SRC_BIT]
                                        ? txw[smcs_pkg::TXW_LAST_BIT] : 1'b0;
                        next_sel = line_code;
                        next_st = smcs_pkg::SMCS_LEAD;
                        next_divcnt = 8'h01;
                        // holding line zero needs mode-fault detection switched off
                        if (cfg[cfg_idx][smcs_pkg::CFG_HOLD_BIT] && !line_code[0]
                            && !mode_register[smcs_pkg::MODE_MFD_BIT]) begin
                            bad_ev = 1'b1;
                        end
                    end
                end else if (last_req) begin
                    next_last_req = 1'b0;
                    next_sel = smcs_pkg::SEL_IDLE;
                    next_held = smcs_pkg::SEL_IDLE;
                end
            end
            smcs_pkg::SMCS_LEAD: begin
                next_mosi_r = shreg[15]; // msb first from the left-aligned word
                next_st = smcs_pkg::SMCS_SHIFT;
                next_divcnt = 8'h01;
                next_sck = 1'b0;
            end
            smcs_pkg::SMCS_SHIFT: begin
                // modulus counter: a bit lasts div_cur cycles; divisor 1 leaves no room for a high phase
                if (divcnt >= div_cur) begin
                    next_divcnt = 8'h01;
                    next_sck = 1'b0;
                    next_bitcnt = bitcnt - 5'd1;
                    next_shreg = {shreg[14:0], miso_s2};
                    if (bitcnt == 5'd1) begin
                        next_st = smcs_pkg::SMCS_GAP;
                        next_gapcnt = 2'd0;
                    end else begin
                        next_mosi_r = shreg[14];
                    end
                end else begin
                    next_divcnt = divcnt + 8'h01;
                    if (divcnt == {1'b0, div_cur[7:1]}) next_sck = 1'b1;
                end
            end
            smcs_pkg::SMCS_GAP: begin
                next_sck = 1'b0;
                if (gapcnt == 2'(smcs_pkg::REL_GAP_CYC - 1)) begin
                    next_st = smcs_pkg::SMCS_IDLE;
                    done_ev = 1'b1;
                    next_rx_word = shreg; // received bits sit at the low end
                    if (hold_cur && !last_cur) begin
                        next_held = sel;
                    end else begin
                        next_sel = smcs_pkg::SEL_IDLE;
                        next_held = smcs_pkg::SEL_IDLE;
                    end
                    if (rel_cur) next_sel = smcs_pkg::SEL_IDLE;
                end else begin
                    next_gapcnt = gapcnt + 2'd1;
                end
            end
            default: next_st = smcs_pkg::SMCS_IDLE;
        endcase
        // sticky events: set wins over clear
        if (done_ev) next_stat[smcs_pkg::ST_DONE_BIT] = 1'b1;
        if (bad_ev) next_stat[smcs_pkg::ST_BAD_BIT] = 1'b1;
        if (!next_txw_full && txw_full) next_stat[smcs_pkg::ST_EMPTY_BIT] = 1'b1;
    end

    // register all state
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            enabled <= 1'b0;
            mode_register <= smcs_pkg::RESET_ZERO;
            cfg <= '{default: smcs_pkg::RESET_ZERO};
            txw <= smcs_pkg::RESET_ZERO;
            txw_full <= 1'b0;
            stat <= 3'h0;
            mask <= 3'h0;
            last_req <= 1'b0;
            st <= smcs_pkg::SMCS_IDLE;
            shreg <= 16'h0000;
            bitcnt <= 5'h00;
            divcnt <= 8'h00;
            div_cur <= 8'h00;
            sck <= 1'b0;
            sel <= smcs_pkg::SEL_IDLE;
            held <= smcs_pkg::SEL_IDLE;
            hold_cur <= 1'b0;
            rel_cur <= 1'b0;
            last_cur <= 1'b0;
            gapcnt <= 2'd0;
            mosi_r <= 1'b0;
            rx_word <= 16'h0000;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
            hrdata <= smcs_pkg::RESET_ZERO;
            tx_dma_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            enabled <= next_enabled;
            mode_register <= next_mode_register;
            cfg <= next_cfg;
            txw <= next_txw;
            txw_full <= next_txw_full;
            stat <= next_stat;
            mask <= next_mask;
            last_req <= next_last_req;
            st <= next_st;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            divcnt <= next_divcnt;
            div_cur <= next_div_cur;
            sck <= next_sck;
            sel <= next_sel;
            held <= next_held;
            hold_cur <= next_hold_cur;
            rel_cur <= next_rel_cur;
            last_cur <= next_last_cur;
            gapcnt <= next_gapcnt;
            mosi_r <= next_mosi_r;
            rx_word <= next_rx_word;
            miso_s1 <= miso;
            miso_s2 <= miso_s1;
            hrdata <= next_rdata;
            tx_dma_req <= next_enabled && !next_txw_full;
            irq <= |(next_stat & next_mask);
        end
    end

    // fixed bus answer and serial pins
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign serial_clock_out = sck;
    assign mosi = mosi_r;
    assign sel_n = sel;
endmodule : smcs_master
`default_nettype wire

// File: sim/smcs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module smcs_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // link and events
    input wire logic serial_clock_out,
    input wire logic [3:0] sel_n,
    input wire logic tx_dma_req,
    input wire logic irq
);
    logic wr_q;
    logic [7:0] adr_q;
    logic dec_q;
    logic en_q;
    logic [31:0] mask_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // shadow copies of the mode, control and mask writes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= 1'b0;
            adr_q <= 8'h00;
            dec_q <= 1'b0;
            en_q <= 1'b0;
            mask_q <= 32'h0000_0000;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            adr_q <= haddr;
            if (wr_q && adr_q == smcs_pkg::OFF_MODE) dec_q <= hwdata[smcs_pkg::MODE_DEC_BIT];
            if (wr_q && adr_q == smcs_pkg::OFF_MASK) mask_q <= hwdata;
            if (wr_q && adr_q == smcs_pkg::OFF_CTRL && hwdata[smcs_pkg::CTRL_EN_BIT]) en_q <= 1'b1;
            if (wr_q && adr_q == smcs_pkg::OFF_CTRL && hwdata[smcs_pkg::CTRL_DIS_BIT]) en_q <= 1'b0;
        end
    end
    // bus answers, select line, dma request and interrupt behaviour
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
    a_zero_wait: assert property (hreadyout) else $error("wait state inserted");
    a_reset_idle: assert property ($rose(nrst) |-> sel_n == 4'hF)
        else $error("select not idle after reset");
    a_single_line: assert property (!dec_q |-> sel_n inside {4'hE, 4'hD, 4'hB, 4'h7, 4'hF})
        else $error("more than one select line low");
    a_clk_in_frame: assert property (serial_clock_out |-> sel_n != 4'hF)
        else $error("serial clock with no select");
    a_sel_steady: assert property (serial_clock_out |-> $stable(sel_n))
        else $error("select moved during a character");
    a_dma_enabled: assert property (tx_dma_req |-> en_q || $past(en_q))
        else $error("dma request while disabled");
    a_irq_masked: assert property (irq |-> mask_q != 32'h0000_0000 || $past(mask_q) != 32'h0000_0000)
        else $error("interrupt with all sources masked");
    // main scenarios reached
    c_line_zero: cover property ($fell(sel_n[0]));
    c_irq: cover property ($rose(irq));
    c_decoded: cover property (dec_q && sel_n == 4'h5);
endmodule : smcs_properties
bind smcs_master smcs_properties u_props (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .serial_clock_out, .sel_n, .tx_dma_req, .irq);
`default_nettype wire

// File: sim/smcs_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module smcs_slave_model (
    // clock and capture clear
    input wire logic sys_clk,
    input wire logic clr,
    // serial link
    input wire logic serial_clock_out,
    input wire logic mosi,
    input wire logic [3:0] sel_n,
    output logic miso,
    // captured character
    output var int bits,
    output logic [15:0] data,
    output logic [3:0] sel_seen,
    output var int period
);
    logic sck_q = 1'b0;
    int cnt = 0;
    logic [15:0] reply = 16'hC3A5;
    initial miso = 1'b0;
    // mode 0 slave: sample on rising clock, shift reply out while clock is low
    always @(posedge sys_clk) begin
        sck_q <= serial_clock_out;
        cnt <= cnt + 1;
        if (clr) begin
            bits <= 0;
            data <= 16'h0000;
            sel_seen <= 4'hF;
        end else if (serial_clock_out && !sck_q && sel_n != 4'hF) begin
            bits <= bits + 1;
            data <= {data[14:0], mosi};
            sel_seen <= sel_n;
            period <= cnt;
            cnt <= 1;
        end
        // a released line shows no stale value
        if (sel_n == 4'hF) miso <= ~miso;
        else if (!serial_clock_out) miso <= reply[4'(15 - bits)];
    end
endmodule : smcs_slave_model
`default_nettype wire

// File: sim/spi_master_chip_select_and_bit_rate_tb.sv
`timescale 1ns/100ps
`default_nettype none
module spi_master_chip_select_and_bit_rate_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, sck, mosi, miso, dma_req, irq, irq_exp;
    logic clr = 1'b0;
    logic [3:0] sel_n, sel_seen;
    logic [15:0] sdata;
    int bits, period;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #20 sys_clk = ~sys_clk;
    smcs_master u_dut (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .serial_clock_out(sck), .mosi, .miso, .sel_n, .tx_dma_req(dma_req), .irq);
    smcs_slave_model u_slave (.sys_clk, .clr, .serial_clock_out(sck), .mosi, .sel_n, .miso, .bits,
        .data(sdata), .sel_seen, .period);
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // one single word transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic poll(input logic [31:0] m);
        for (int i = 0; i < 400; i++) begin
            ahb(1'b0, smcs_pkg::OFF_STAT, 32'h0000_0000);
            if ((rd & m) !== 32'h0000_0000) break;
        end
        chk(m, rd & m, "status flag");
    endtask : poll
    // send one word, then check what the slave saw and the interrupt
    task automatic xfer(input logic [31:0] w, input int n, input logic [3:0] s);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        ahb(1'b1, smcs_pkg::OFF_TXW, w);
        poll(32'h0000_0001);
        chk(32'(n), 32'(bits), "bit count");
        chk(32'(w[15:0] & 16'((1 << n) - 1)), 32'(sdata), "shifted data");
        chk(32'(s), 32'(sel_seen), "select used");
        repeat (2) @(posedge sys_clk);
        chk(32'(irq_exp), 32'(irq), "irq level");
        ahb(1'b1, smcs_pkg::OFF_STAT, 32'h0000_0005);
        repeat (2) @(posedge sys_clk);
        chk(32'h0, 32'(irq), "irq cleared");
    endtask : xfer
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        irq_exp = 1'b1;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        chk(32'h0000_000F, 32'(sel_n), "idle select");
        ahb(1'b0, smcs_pkg::OFF_CFG0, 32'h0000_0000);
        chk(32'h0000_0000, rd, "config reset");
        ahb(1'b0, 8'h80, 32'h0000_0000);
        chk(32'h0000_0000, rd, "unmapped read");
        ahb(1'b1, smcs_pkg::OFF_MASK, 32'h0000_0001);
        ahb(1'b1, smcs_pkg::OFF_CTRL, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk(32'h1, 32'(dma_req), "dma request");
        ahb(1'b1, smcs_pkg::OFF_MODE, 32'h000E_0000);
        for (int k = 0; k <= 8; k++) begin
            ahb(1'b1, smcs_pkg::OFF_CFG0, 32'((k << 4) | ((2 + k % 3) << 8)));
            xfer(32'h0000_B5A3 + 32'(k), 8 + k, 4'hE);
            chk(32'(2 + k % 3), 32'(period), "clock period");
            chk(32'h0000_000F, 32'(sel_n), "released select");
        end
        $display("test widths and divisors done");
        clr <= 1'b1;
        ahb(1'b1, smcs_pkg::OFF_CFG0, 32'h0000_0390);
        clr <= 1'b0;
        ahb(1'b1, smcs_pkg::OFF_TXW, 32'h0000_1234);
        poll(32'h0000_0004);
        chk(32'h0, 32'(bits), "reserved width shifted");
        ahb(1'b1, smcs_pkg::OFF_STAT, 32'h0000_0005);
        $display("test reserved width done");
        ahb(1'b1, smcs_pkg::OFF_MODE, 32'h0000_0002);
        ahb(1'b1, smcs_pkg::OFF_CFG0, 32'h0000_0310);
        ahb(1'b1, 8'h34, 32'h0000_0200);
        xfer(32'h0009_005A, 8, 4'hD);
        xfer(32'h0006_01A5, 9, 4'hE);
        $display("test variable select done");
        ahb(1'b1, smcs_pkg::OFF_MODE, 32'h0000_0012);
        ahb(1'b1, smcs_pkg::OFF_CFG0, 32'h0000_020C);
        xfer(32'h000E_003C, 8, 4'hE);
        chk(32'h0000_000E, 32'(sel_n), "held select");
        ahb(1'b1, smcs_pkg::OFF_MODE, 32'h0000_0002);
        ahb(1'b1, smcs_pkg::OFF_TXW, 32'h000E_0011);
        poll(32'h0000_0004);
        poll(32'h0000_0001);
        ahb(1'b1, smcs_pkg::OFF_STAT, 32'h0000_0005);
        ahb(1'b1, smcs_pkg::OFF_CTRL, 32'h0100_0000);
        repeat (2) @(posedge sys_clk);
        chk(32'h0000_000F, 32'(sel_n), "select let go");
        $display("test held select done");
        ahb(1'b1, smcs_pkg::OFF_MASK, 32'h0000_0000);
        irq_exp = 1'b0;
        ahb(1'b1, smcs_pkg::OFF_MODE, 32'h0000_0006);
        ahb(1'b1, smcs_pkg::OFF_CFG0, 32'h0000_0200);
        ahb(1'b1, 8'h34, 32'h0000_0240);
        xfer(32'h0005_0ABC, 12, 4'h5);
        xfer(32'h0003_00C7, 8, 4'h3);
        $display("test decoded select done");
        end_sim();
    end
endmodule : spi_master_chip_select_and_bit_rate_tb
`default_nettype wire
